// file: logic/psrc_consts.vh
`ifndef PSRC_CONSTS_VH
`define PSRC_CONSTS_VH

// Register byte offsets
`define PSRC_OFS_PERIPH_ONE   12'h044
`define PSRC_OFS_IO_PORT      12'h048
`define PSRC_OFS_CAP_TWO      12'h080
`define PSRC_OFS_CAP_FOUR     12'h084

// Reset values
`define PSRC_RST_PERIPH_ONE   32'h00000000
`define PSRC_RST_IO_PORT      32'h00000000

// Implemented (writable) bits, all others read as zero
`define PSRC_IMPL_PERIPH_ONE  32'h000F5137
`define PSRC_IMPL_IO_PORT     32'h000000FF

// Field positions, first peripheral register
`define PSRC_BIT_GPT3         19
`define PSRC_BIT_GPT2         18
`define PSRC_BIT_GPT1         17
`define PSRC_BIT_GPT0         16
`define PSRC_BIT_TW1          14
`define PSRC_BIT_TW0          12
`define PSRC_BIT_QENC         8
`define PSRC_BIT_SS1          5
`define PSRC_BIT_SS0          4
`define PSRC_BIT_AS2          2
`define PSRC_BIT_AS1          1
`define PSRC_BIT_AS0          0

// Field positions, port register
`define PSRC_BIT_PH           7
`define PSRC_BIT_PG           6
`define PSRC_BIT_PF           5
`define PSRC_BIT_PE           4
`define PSRC_BIT_PD           3
`define PSRC_BIT_PC           2
`define PSRC_BIT_PB           1
`define PSRC_BIT_PA           0

`endif

// file: logic/psrc_mask_reg.v
`timescale 1ns/100ps
module psrc_mask_reg #(
    parameter [31:0] IMPL_MASK = 32'hFFFFFFFF,
    parameter [31:0] RESET_VAL = 32'h00000000
) (
    input  wire        sys_clk_i,
    input  wire        rst_i,
    input  wire        wr_en_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] wdata_i,
    input  wire [31:0] cap_mask_i,
    output wire [31:0] q_o
);
    reg [31:0] q_reg;
    reg [31:0] q_next;
    integer    i;

    // Only present, implemented bits in enabled byte lanes take the write
    always @* begin
        q_next = q_reg;
        for (i = 0; i < 32; i = i + 1) begin
            if (wr_en_i && sel_i[i / 8] && IMPL_MASK[i] && cap_mask_i[i]) begin
                q_next[i] = wdata_i[i];
            end
        end
        q_next = q_next & IMPL_MASK;
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            q_reg <= RESET_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule // psrc_mask_reg

// file: logic/psrc_wb_slave.v
`timescale 1ns/100ps
`include "psrc_consts.vh"
module psrc_wb_slave (
    input  wire        sys_clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [11:0] adr_i,
    output wire        ack_o,
    output wire        answer_o,
    output wire        commit_wr_o,
    output reg         hit_one_o,
    output reg         hit_port_o,
    output reg         hit_cap2_o,
    output reg         hit_cap4_o
);
    reg  ack_reg;
    wire req;

    assign req = cyc_i & stb_i;

    // One-cycle ack, dropped the cycle after it was given
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // Address decode on word offset
    always @* begin
        hit_one_o  = 1'b0;
        hit_port_o = 1'b0;
        hit_cap2_o = 1'b0;
        hit_cap4_o = 1'b0;
        if ({adr_i[11:2], 2'b00} == `PSRC_OFS_PERIPH_ONE) begin
            hit_one_o = 1'b1;
        end else if ({adr_i[11:2], 2'b00} == `PSRC_OFS_IO_PORT) begin
            hit_port_o = 1'b1;
        end else if ({adr_i[11:2], 2'b00} == `PSRC_OFS_CAP_TWO) begin
            hit_cap2_o = 1'b1;
        end else if ({adr_i[11:2], 2'b00} == `PSRC_OFS_CAP_FOUR) begin
            hit_cap4_o = 1'b1;
        end
    end

    assign ack_o       = ack_reg;
    assign answer_o    = req & ~ack_reg;
    assign commit_wr_o = req & we_i & ack_reg;
endmodule // psrc_wb_slave

// file: logic/psrc_top.v
// Summary of operation
// (RQ1) Peripheral writes gated by capability mask two
// (RQ2) Port writes gated by capability mask four
// (RQ3) Both registers read/write, reset to zero
// (RQ4) Bits 19:16 reset timers three..zero
// (RQ5) Bit 14 two-wire one, bit 12 zero
// (RQ6) Bit 8 resets quadrature encoder unit
// (RQ7) Bit 5 sync serial one, bit 4 zero
// (RQ8) Bits 2:0 reset async serial two..zero
// (RQ9) Port bits 7:0 reset ports H..A
// (RQ10) Unassigned bits read-only, read as zero
// (RQ11) Software preserves unassigned bits on read-modify-write
// (RQ12) Set bit holds unit in reset
//
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
`include "psrc_consts.vh"
module psrc_top (
    input  wire        sys_clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [11:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output wire        ack_o,
    output reg  [31:0] dat_o,
    input  wire [31:0] capability_mask_two_i,
    input  wire [31:0] capability_mask_four_i,
    output reg         gp_timer_three_rst_o,
    output reg         gp_timer_two_rst_o,
    output reg         gp_timer_one_rst_o,
    output reg         gp_timer_zero_rst_o,
    output reg         twowire_one_rst_o,
    output reg         twowire_zero_rst_o,
    output reg         quad_encoder_rst_o,
    output reg         sync_serial_one_rst_o,
    output reg         sync_serial_zero_rst_o,
    output reg         async_serial_two_rst_o,
    output reg         async_serial_one_rst_o,
    output reg         async_serial_zero_rst_o,
    output reg         io_port_h_rst_o,
    output reg         io_port_g_rst_o,
    output reg         io_port_f_rst_o,
    output reg         io_port_e_rst_o,
    output reg         io_port_d_rst_o,
    output reg         io_port_c_rst_o,
    output reg         io_port_b_rst_o,
    output reg         io_port_a_rst_o
);
    wire        answer;
    wire        commit_wr;
    wire        hit_one;
    wire        hit_port;
    wire        hit_cap2;
    wire        hit_cap4;
    wire [31:0] peripheral_reset_ctl_one;
    wire [31:0] io_port_reset_ctl;
    reg  [31:0] rdata_next;
    wire        timer_three_bit;
    wire        timer_two_bit;
    wire        timer_one_bit;
    wire        timer_zero_bit;
    wire        twowire_one_bit;
    wire        twowire_zero_bit;
    wire        quad_encoder_bit;
    wire        sync_serial_one_bit;
    wire        sync_serial_zero_bit;
    wire        async_serial_two_bit;
    wire        async_serial_one_bit;
    wire        async_serial_zero_bit;
    wire        port_h_bit;
    wire        port_g_bit;
    wire        port_f_bit;
    wire        port_e_bit;
    wire        port_d_bit;
    wire        port_c_bit;
    wire        port_b_bit;
    wire        port_a_bit;

    psrc_wb_slave u_slave (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .cyc_i       (cyc_i),
        .stb_i       (stb_i),
        .we_i        (we_i),
        .adr_i       (adr_i),
        .ack_o       (ack_o),
        .answer_o    (answer),
        .commit_wr_o (commit_wr),
        .hit_one_o   (hit_one),
        .hit_port_o  (hit_port),
        .hit_cap2_o  (hit_cap2),
        .hit_cap4_o  (hit_cap4)
    );

    // Peripheral register, masked by capability two [RQ1] [RQ3] [RQ10]
    psrc_mask_reg #(
        .IMPL_MASK (`PSRC_IMPL_PERIPH_ONE),
        .RESET_VAL (`PSRC_RST_PERIPH_ONE)
    ) u_periph_one (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (commit_wr & hit_one),
        .sel_i      (sel_i),
        .wdata_i    (dat_i),
        .cap_mask_i (capability_mask_two_i),
        .q_o        (peripheral_reset_ctl_one)
    );

    // Port register, masked by capability four [RQ2] [RQ3] [RQ10]
    psrc_mask_reg #(
        .IMPL_MASK (`PSRC_IMPL_IO_PORT),
        .RESET_VAL (`PSRC_RST_IO_PORT)
    ) u_io_port (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (commit_wr & hit_port),
        .sel_i      (sel_i),
        .wdata_i    (dat_i),
        .cap_mask_i (capability_mask_four_i),
        .q_o        (io_port_reset_ctl)
    );

    // Read mux, unmapped addresses read zero
    always @* begin
        rdata_next = 32'h00000000;
        if (hit_one) begin
            rdata_next = peripheral_reset_ctl_one;
        end else if (hit_port) begin
            rdata_next = io_port_reset_ctl;
        end else if (hit_cap2) begin
            rdata_next = capability_mask_two_i;
        end else if (hit_cap4) begin
            rdata_next = capability_mask_four_i;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (answer) begin
            dat_o <= rdata_next;
        end
    end

    // Per-unit control bits, reset lines follow them one cycle later [RQ12]
    assign timer_three_bit       = peripheral_reset_ctl_one[`PSRC_BIT_GPT3]; // [RQ4]
    assign timer_two_bit         = peripheral_reset_ctl_one[`PSRC_BIT_GPT2]; // [RQ4]
    assign timer_one_bit         = peripheral_reset_ctl_one[`PSRC_BIT_GPT1]; // [RQ4]
    assign timer_zero_bit        = peripheral_reset_ctl_one[`PSRC_BIT_GPT0]; // [RQ4]
    assign twowire_one_bit       = peripheral_reset_ctl_one[`PSRC_BIT_TW1]; // [RQ5]
    assign twowire_zero_bit      = peripheral_reset_ctl_one[`PSRC_BIT_TW0]; // [RQ5]
    assign quad_encoder_bit      = peripheral_reset_ctl_one[`PSRC_BIT_QENC]; // [RQ6]
    assign sync_serial_one_bit   = peripheral_reset_ctl_one[`PSRC_BIT_SS1]; // [RQ7]
    assign sync_serial_zero_bit  = peripheral_reset_ctl_one[`PSRC_BIT_SS0]; // [RQ7]
    assign async_serial_two_bit  = peripheral_reset_ctl_one[`PSRC_BIT_AS2]; // [RQ8]
    assign async_serial_one_bit  = peripheral_reset_ctl_one[`PSRC_BIT_AS1]; // [RQ8]
    assign async_serial_zero_bit = peripheral_reset_ctl_one[`PSRC_BIT_AS0]; // [RQ8]
    assign port_h_bit            = io_port_reset_ctl[`PSRC_BIT_PH]; // [RQ9]
    assign port_g_bit            = io_port_reset_ctl[`PSRC_BIT_PG]; // [RQ9]
    assign port_f_bit            = io_port_reset_ctl[`PSRC_BIT_PF]; // [RQ9]
    assign port_e_bit            = io_port_reset_ctl[`PSRC_BIT_PE]; // [RQ9]
    assign port_d_bit            = io_port_reset_ctl[`PSRC_BIT_PD]; // [RQ9]
    assign port_c_bit            = io_port_reset_ctl[`PSRC_BIT_PC]; // [RQ9]
    assign port_b_bit            = io_port_reset_ctl[`PSRC_BIT_PB]; // [RQ9]
    assign port_a_bit            = io_port_reset_ctl[`PSRC_BIT_PA]; // [RQ9]

    // Timer three reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            gp_timer_three_rst_o <= 1'b0;
        end else begin
            gp_timer_three_rst_o <= timer_three_bit; // [RQ12]
        end
    end

    // Timer two reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            gp_timer_two_rst_o <= 1'b0;
        end else begin
            gp_timer_two_rst_o <= timer_two_bit; // [RQ12]
        end
    end

    // Timer one reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            gp_timer_one_rst_o <= 1'b0;
        end else begin
            gp_timer_one_rst_o <= timer_one_bit; // [RQ12]
        end
    end

    // Timer zero reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            gp_timer_zero_rst_o <= 1'b0;
        end else begin
            gp_timer_zero_rst_o <= timer_zero_bit; // [RQ12]
        end
    end

    // Two-wire unit one reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            twowire_one_rst_o <= 1'b0;
        end else begin
            twowire_one_rst_o <= twowire_one_bit; // [RQ12]
        end
    end

    // Two-wire unit zero reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            twowire_zero_rst_o <= 1'b0;
        end else begin
            twowire_zero_rst_o <= twowire_zero_bit; // [RQ12]
        end
    end

    // Quadrature encoder reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            quad_encoder_rst_o <= 1'b0;
        end else begin
            quad_encoder_rst_o <= quad_encoder_bit; // [RQ12]
        end
    end

    // Sync serial unit one reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync_serial_one_rst_o <= 1'b0;
        end else begin
            sync_serial_one_rst_o <= sync_serial_one_bit; // [RQ12]
        end
    end

    // Sync serial unit zero reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync_serial_zero_rst_o <= 1'b0;
        end else begin
            sync_serial_zero_rst_o <= sync_serial_zero_bit; // [RQ12]
        end
    end

    // Async serial unit two reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            async_serial_two_rst_o <= 1'b0;
        end else begin
            async_serial_two_rst_o <= async_serial_two_bit; // [RQ12]
        end
    end

    // Async serial unit one reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            async_serial_one_rst_o <= 1'b0;
        end else begin
            async_serial_one_rst_o <= async_serial_one_bit; // [RQ12]
        end
    end

    // Async serial unit zero reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            async_serial_zero_rst_o <= 1'b0;
        end else begin
            async_serial_zero_rst_o <= async_serial_zero_bit; // [RQ12]
        end
    end

    // Port H reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_port_h_rst_o <= 1'b0;
        end else begin
            io_port_h_rst_o <= port_h_bit; // [RQ12]
        end
    end

    // Port G reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_port_g_rst_o <= 1'b0;
        end else begin
            io_port_g_rst_o <= port_g_bit; // [RQ12]
        end
    end

    // Port F reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_port_f_rst_o <= 1'b0;
        end else begin
            io_port_f_rst_o <= port_f_bit; // [RQ12]
        end
    end

    // Port E reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_port_e_rst_o <= 1'b0;
        end else begin
            io_port_e_rst_o <= port_e_bit; // [RQ12]
        end
    end

    // Port D reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_port_d_rst_o <= 1'b0;
        end else begin
            io_port_d_rst_o <= port_d_bit; // [RQ12]
        end
    end

    // Port C reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_port_c_rst_o <= 1'b0;
        end else begin
            io_port_c_rst_o <= port_c_bit; // [RQ12]
        end
    end

    // Port B reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_port_b_rst_o <= 1'b0;
        end else begin
            io_port_b_rst_o <= port_b_bit; // [RQ12]
        end
    end

    // Port A reset line
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_port_a_rst_o <= 1'b0;
        end else begin
            io_port_a_rst_o <= port_a_bit; // [RQ12]
        end
    end
endmodule // psrc_top

// file: tb/psrc_top_asserts.sv
`timescale 1ns/100ps
module psrc_top_asserts (
    input wire        sys_clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire [11:0] adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i, dat_o, capability_mask_two_i, capability_mask_four_i,
    input wire        gp_timer_three_rst_o, gp_timer_two_rst_o, gp_timer_one_rst_o, gp_timer_zero_rst_o,
    input wire        twowire_one_rst_o, twowire_zero_rst_o, quad_encoder_rst_o,
    input wire        sync_serial_one_rst_o, sync_serial_zero_rst_o,
    input wire        async_serial_two_rst_o, async_serial_one_rst_o, async_serial_zero_rst_o,
    input wire        io_port_h_rst_o, io_port_g_rst_o, io_port_f_rst_o, io_port_e_rst_o,
    input wire        io_port_d_rst_o, io_port_c_rst_o, io_port_b_rst_o, io_port_a_rst_o
);
    wire rd_one  = ack_o && !we_i && adr_i[11:2] == 10'h011;
    wire rd_port = ack_o && !we_i && adr_i[11:2] == 10'h012;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence wr_one;  ack_o && we_i && adr_i[11:2] == 10'h011; endsequence
    sequence wr_port; ack_o && we_i && adr_i[11:2] == 10'h012; endsequence
    a_ack_prompt: assert property ($rose(cyc_i && stb_i) |=> ack_o)
        else $error("ack not one cycle after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_one_rsv: assert property (rd_one |-> (dat_o & ~32'h000F5137) == 32'h00000000)
        else $error("reserved peripheral bits not zero");
    a_port_rsv: assert property (rd_port |-> dat_o[31:8] == 24'h000000)
        else $error("reserved port bits not zero");
    a_one_fields: assert property (rd_one |-> {dat_o[19:16], dat_o[14], dat_o[12], dat_o[8], dat_o[5:4], dat_o[2:0]}
        == {gp_timer_three_rst_o, gp_timer_two_rst_o, gp_timer_one_rst_o, gp_timer_zero_rst_o, twowire_one_rst_o,
        twowire_zero_rst_o, quad_encoder_rst_o, sync_serial_one_rst_o, sync_serial_zero_rst_o,
        async_serial_two_rst_o, async_serial_one_rst_o, async_serial_zero_rst_o})
        else $error("peripheral outputs differ from register");
    a_port_fields: assert property (rd_port |-> dat_o[7:0] == {io_port_h_rst_o, io_port_g_rst_o, io_port_f_rst_o,
        io_port_e_rst_o, io_port_d_rst_o, io_port_c_rst_o, io_port_b_rst_o, io_port_a_rst_o})
        else $error("port outputs differ from register");
    a_timer_write: assert property (wr_one ##0 (sel_i[2] && capability_mask_two_i[19])
        |-> ##2 gp_timer_three_rst_o == $past(dat_i[19], 2))
        else $error("timer reset not written");
    a_timer_masked: assert property (wr_one ##0 (sel_i[2] && !capability_mask_two_i[18])
        |-> ##2 $stable(gp_timer_two_rst_o))
        else $error("absent timer reset changed");
    a_port_write: assert property (wr_port ##0 (sel_i[0] && capability_mask_four_i[0])
        |-> ##2 io_port_a_rst_o == $past(dat_i[0], 2))
        else $error("port reset not written");
    a_port_masked: assert property (wr_port ##0 (sel_i[0] && !capability_mask_four_i[7])
        |-> ##2 $stable(io_port_h_rst_o))
        else $error("absent port reset changed");
endmodule // psrc_top_asserts

// file: tb/test_psrc_top.sv
`timescale 1ns/100ps
module test_psrc_top;
    typedef struct packed {logic [11:0] a; logic [3:0] s; logic [31:0] d, c, e;} psrc_row_t;
    reg         sys_clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg  [11:0] adr_i = 12'h000;
    reg  [3:0]  sel_i = 4'h0;
    reg  [31:0] dat_i = 32'h0, cap_two = 32'h0, cap_four = 32'h0, rd;
    wire        ack_o;
    wire [31:0] dat_o;
    wire [11:0] u;
    wire [7:0]  p;
    wire [31:0] one_v = {12'h0, u[11:8], 1'b0, u[7], 1'b0, u[6], 3'h0, u[5], 2'h0, u[4:3], 1'b0, u[2:0]};
    psrc_row_t  rows [0:9];
    integer     n_fail = 0, total_checks = 0, i;
    always #2 sys_clk_i = ~sys_clk_i;
    psrc_top u_psrc_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
        .capability_mask_two_i(cap_two), .capability_mask_four_i(cap_four),
        .gp_timer_three_rst_o(u[11]), .gp_timer_two_rst_o(u[10]), .gp_timer_one_rst_o(u[9]),
        .gp_timer_zero_rst_o(u[8]), .twowire_one_rst_o(u[7]), .twowire_zero_rst_o(u[6]),
        .quad_encoder_rst_o(u[5]), .sync_serial_one_rst_o(u[4]), .sync_serial_zero_rst_o(u[3]),
        .async_serial_two_rst_o(u[2]), .async_serial_one_rst_o(u[1]), .async_serial_zero_rst_o(u[0]),
        .io_port_h_rst_o(p[7]), .io_port_g_rst_o(p[6]), .io_port_f_rst_o(p[5]), .io_port_e_rst_o(p[4]),
        .io_port_d_rst_o(p[3]), .io_port_c_rst_o(p[2]), .io_port_b_rst_o(p[1]), .io_port_a_rst_o(p[0]));
    task wb(input w, input [11:0] a, input [3:0] s, input [31:0] d, output [31:0] r);
        integer k;
        begin
            k = 0;
            @(posedge sys_clk_i);
            {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
            do begin
                @(posedge sys_clk_i);
                k = k + 1;
            end while (ack_o !== 1'b1 && k < 50);
            if (ack_o !== 1'b1) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t ack=%h exp=%h", $time, ack_o, 1'b1);
            end
            r = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks=%0d mismatches=%0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        #20000;
        n_fail = n_fail + 1;
        test_done;
    end
    initial begin
        rows = '{'{12'h044, 4'hF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000F5137},
                 '{12'h044, 4'hF, 32'h00000000, 32'hFFFFFFFF, 32'h00000000},
                 '{12'h044, 4'hF, 32'hFFFFFFFF, 32'h000A0015, 32'h000A0015},
                 '{12'h044, 4'h1, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000A0037},
                 '{12'h044, 4'hF, 32'h00000000, 32'h000F0000, 32'h00000037},
                 '{12'h048, 4'hF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000000FF},
                 '{12'h048, 4'hF, 32'h00000055, 32'h0000000F, 32'h000000F5},
                 '{12'h048, 4'h2, 32'h00000000, 32'hFFFFFFFF, 32'h000000F5},
                 '{12'h048, 4'hF, 32'h00000000, 32'hFFFFFFFF, 32'h00000000},
                 '{12'h044, 4'hF, 32'h00000000, 32'hFFFFFFFF, 32'h00000000}};
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 12'h044, 4'hF, 32'h0, rd); chk(rd, 32'h0);
        wb(1'b0, 12'h048, 4'hF, 32'h0, rd); chk(rd, 32'h0);
        chk(one_v | {24'h0, p}, 32'h0);
        $display("reset values done");
        for (i = 0; i < 10; i = i + 1) begin
            cap_two <= rows[i].c;
            cap_four <= rows[i].c;
            wb(1'b1, rows[i].a, rows[i].s, rows[i].d, rd);
            wb(1'b0, rows[i].a, 4'hF, 32'h0, rd);
            chk(rd, rows[i].e);
            chk(rows[i].a == 12'h044 ? one_v : {24'h0, p}, rows[i].e);
        end
        $display("table done");
        cap_two <= 32'hFFFFFFFF;
        cap_four <= 32'h000000A5;
        wb(1'b1, 12'h100, 4'hF, 32'hFFFFFFFF, rd);
        wb(1'b0, 12'h100, 4'hF, 32'h0, rd); chk(rd, 32'h0);
        wb(1'b0, 12'h084, 4'hF, 32'h0, rd); chk(rd, 32'h000000A5);
        wb(1'b0, 12'h080, 4'hF, 32'h0, rd); chk(rd, 32'hFFFFFFFF);
        wb(1'b0, 12'h044, 4'hF, 32'h0, rd);
        wb(1'b1, 12'h044, 4'hF, rd | 32'h00000100, rd);
        wb(1'b0, 12'h044, 4'hF, 32'h0, rd); chk(rd, 32'h00000100);
        wb(1'b1, 12'h048, 4'hF, 32'hFFFFFFFF, rd);
        wb(1'b0, 12'h048, 4'hF, 32'h0, rd); chk(rd, 32'h000000A5);
        $display("unmapped and read-modify-write done");
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        chk(one_v | {24'h0, p}, 32'h0);
        wb(1'b0, 12'h048, 4'hF, 32'h0, rd); chk(rd, 32'h0);
        $display("mid-run reset done");
        test_done;
    end
endmodule // test_psrc_top
bind psrc_top psrc_top_asserts u_psrc_top_asserts (.*);
